/* spwm_pkg.sv */
// Package of the standard PWM channel: register map, field layout, reset values, types.
// Assumes a 10 MHz system clock and a simple strobe register port.
package spwm_pkg;

	// Register offsets
	localparam logic [3:0] SPWM_ADDR_CONTROL = 4'h0;
	localparam logic [3:0] SPWM_ADDR_DUTY_UPPER = 4'h1;
	localparam logic [3:0] SPWM_ADDR_DUTY_SHADOW = 4'h2;
	localparam logic [3:0] SPWM_ADDR_TIMER_SELECT = 4'h3;
	localparam logic [3:0] SPWM_ADDR_TIMER_CONTROL = 4'h4;
	localparam logic [3:0] SPWM_ADDR_PERIOD_LIMIT = 4'h5;
	localparam logic [3:0] SPWM_ADDR_PERIOD_COUNT = 4'h6;
	// Flags sit above the last timer so that no timer register shares their address
	localparam logic [3:0] SPWM_ADDR_FLAGS = 4'hd;
	localparam int SPWM_TIMER_STRIDE = 3;

	// Control register fields
	localparam int SPWM_MODE_LSB = 0;
	localparam int SPWM_DUTY_LOW_LSB = 4;
	localparam int SPWM_BRIDGE_LSB = 6;
	localparam logic [3:0] SPWM_MODE_PWM = 4'hc;

	// Timer control fields
	localparam int SPWM_PRESCALE_LSB = 0;
	localparam int SPWM_RUN_BIT = 2;
	localparam int SPWM_POSTSCALE_LSB = 3;

	// Reset values
	localparam logic [7:0] SPWM_RST_CONTROL = 8'h00;
	localparam logic [7:0] SPWM_RST_DUTY = 8'h00;
	localparam logic [7:0] SPWM_RST_LIMIT = 8'hff;
	localparam logic [7:0] SPWM_RST_TCON = 8'h00;
	localparam logic [1:0] SPWM_RST_TSEL = 2'h0;

	// Timing: oscillator phases per timer increment
	localparam int SPWM_OSC_PHASES = 4;
	localparam int SPWM_CLK_HZ = 10000000;

	typedef enum logic [1:0] {
		SPWM_PS_1 = 2'h0,
		SPWM_PS_4 = 2'h1,
		SPWM_PS_16 = 2'h2,
		SPWM_PS_64 = 2'h3
	} spwm_prescale_e;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} spwm_bus_s;

	typedef struct packed {
		logic [1:0] bridge;
		logic [1:0] duty_low_bits;
		logic [3:0] channel_mode_field;
	} spwm_control_s;

	typedef struct packed {
		logic [7:0] period_limit;
		logic [7:0] period_count;
		logic [7:0] period_timer_control;
		logic period_flag;
		logic [5:0] prescale_count;
	} spwm_timer_s;

endpackage

/* spwm_channel.sv */
// Standard PWM channel with three selectable 8-bit period timers and a register port.
// Assumes one clock, synchronous active-low reset, a pin direction bit held outside,
// and a sleep level produced by logic on the same clock.
//
// What this block does
// - Period is (limit+1) times 4 oscillator periods times prescale ratio.
// - Count equal to limit clears on next increment, starting new period.
// - Output goes high at period start unless duty is zero.
// - Duty copied into shadow at every period boundary in PWM mode.
// - Duty registers writable anytime without disturbing current period.
// - Duty is 10 bits: upper byte plus two control low bits.
// - Shadow is read-only in PWM mode; writes ignored.
// - Time base is timer count extended by two low bits.
// - Writing zero to control releases the output pin.
// - Two-bit select picks one of three period timers.
// - Postscaler never affects the output period.
// - Output driven low when time base equals duty shadow.
// - Prescale 1:1 uses oscillator phase; otherwise prescaler bits.
// - Duty beyond period never clears; pin stays unchanged.
// - In sleep timers stop and state and pin are held.
`timescale 1ns/10ps
module spwm_channel
	import spwm_pkg::*;
#(
	parameter int NUM_TIMERS = 3
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Register port
	input wire spwm_pkg::spwm_bus_s bus_i,
	output logic [7:0] rdata_o,
	// System
	input wire logic sleep_i,
	// Output pin
	output logic pwm_o,
	output logic pwm_oe_n_o,
	output logic pin_owned_o
);
	import spwm_pkg::*;

	function automatic logic [5:0] prescale_mask(input logic [1:0] sel);
		case (sel)
			SPWM_PS_1: prescale_mask = 6'h00;
			SPWM_PS_4: prescale_mask = 6'h03;
			SPWM_PS_16: prescale_mask = 6'h0f;
			default: prescale_mask = 6'h3f;
		endcase
	endfunction

	// Two low time-base bits: oscillator phase at 1:1, else the top prescaler bits
	function automatic logic [1:0] time_low_bits(input logic [5:0] m, input logic [1:0] ph,
			input logic [5:0] pc);
		if (m == 6'h00) begin
			time_low_bits = ph;
		end else if (m[5:4] != 2'h0) begin
			time_low_bits = pc[5:4];
		end else if (m[3:2] != 2'h0) begin
			time_low_bits = pc[3:2];
		end else begin
			time_low_bits = pc[1:0];
		end
	endfunction

	function automatic logic [3:0] timer_addr(input logic [3:0] base, input int t);
		timer_addr = base + 4'(t * SPWM_TIMER_STRIDE);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State
	spwm_control_s control, next_control;
	logic [7:0] duty_upper_byte, next_duty_upper_byte;
	logic [9:0] duty_shadow, next_duty_shadow;
	logic [1:0] timer_select_field, next_timer_select_field;
	spwm_timer_s timers [NUM_TIMERS];
	spwm_timer_s next_timers [NUM_TIMERS];
	logic [1:0] osc_phase, next_osc_phase;
	logic pwm, next_pwm;
	logic oe_n, next_oe_n;
	logic owned, next_owned;
	logic [7:0] rdata, next_rdata;

	// Combinational helpers
	logic [1:0] tsel;
	logic pwm_mode;
	logic [9:0] next_time_base;
	logic boundary;
	logic [5:0] mask;
	logic [NUM_TIMERS-1:0] wrap;

	////////////////////////////////////////////////////////////////////////////////
	// Timers and time base
	always_comb begin
		tsel = (timer_select_field < 2'(NUM_TIMERS)) ? timer_select_field : 2'h0;
		pwm_mode = (control.channel_mode_field == SPWM_MODE_PWM);
		next_osc_phase = sleep_i ? osc_phase : osc_phase + 2'h1;
		wrap = '0;
		for (int t = 0; t < NUM_TIMERS; t++) begin
			next_timers[t] = timers[t];
			mask = prescale_mask(timers[t].period_timer_control[SPWM_PRESCALE_LSB +: 2]);
			// One increment per 4 oscillator phases times prescale; postscale unused
			if (timers[t].period_timer_control[SPWM_RUN_BIT] && !sleep_i
					&& osc_phase == 2'(SPWM_OSC_PHASES - 1)) begin
				next_timers[t].prescale_count = (timers[t].prescale_count + 6'h01) & mask;
				if (timers[t].prescale_count == mask) begin
					if (timers[t].period_count == timers[t].period_limit) begin
						wrap[t] = 1'b1;
						next_timers[t].period_count = 8'h00;
					end else begin
						next_timers[t].period_count = timers[t].period_count + 8'h01;
					end
				end
			end
			if (bus_i.wr && bus_i.addr == timer_addr(SPWM_ADDR_TIMER_CONTROL, t)) begin
				next_timers[t].period_timer_control = bus_i.wdata;
			end
			if (bus_i.wr && bus_i.addr == timer_addr(SPWM_ADDR_PERIOD_LIMIT, t)) begin
				next_timers[t].period_limit = bus_i.wdata;
			end
			if (bus_i.wr && bus_i.addr == timer_addr(SPWM_ADDR_PERIOD_COUNT, t)) begin
				next_timers[t].period_count = bus_i.wdata;
				next_timers[t].prescale_count = 6'h00;
			end
			// Write one clears the flag; a boundary in the same cycle wins
			if (bus_i.wr && bus_i.addr == SPWM_ADDR_FLAGS && bus_i.wdata[t]) begin
				next_timers[t].period_flag = 1'b0;
			end
			if (wrap[t]) begin
				next_timers[t].period_flag = 1'b1;
			end
		end
		mask = prescale_mask(timers[tsel].period_timer_control[SPWM_PRESCALE_LSB +: 2]);
		// Value the time base takes at the next edge, so the pin falls on the edge
		// at which the time base reaches the duty, as it rises on the boundary edge
		next_time_base = {next_timers[tsel].period_count,
			time_low_bits(mask, next_osc_phase, next_timers[tsel].prescale_count)};
		boundary = wrap[tsel];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output and duty shadow
	always_comb begin
		next_duty_shadow = duty_shadow;
		next_pwm = pwm;
		next_oe_n = 1'b1;
		next_owned = 1'b0;
		if (pwm_mode) begin
			next_owned = 1'b1;
			next_oe_n = 1'b0;
			if (boundary) begin
				next_duty_shadow = {duty_upper_byte, control.duty_low_bits};
				next_pwm = ({duty_upper_byte, control.duty_low_bits} != 10'h000);
			end else if (!sleep_i && next_time_base == duty_shadow) begin
				next_pwm = 1'b0;
			end
		end else begin
			next_pwm = 1'b0;
			if (bus_i.wr && bus_i.addr == SPWM_ADDR_DUTY_SHADOW) begin
				next_duty_shadow = {bus_i.wdata, duty_shadow[1:0]};
			end
		end
		if (control == SPWM_RST_CONTROL) begin
			next_owned = 1'b0;
			next_oe_n = 1'b1;
			next_pwm = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register port
	always_comb begin
		next_control = control;
		next_duty_upper_byte = duty_upper_byte;
		next_timer_select_field = timer_select_field;
		next_rdata = 8'h00;
		for (int t = 0; t < NUM_TIMERS; t++) begin
			if (bus_i.rd && bus_i.addr == timer_addr(SPWM_ADDR_TIMER_CONTROL, t)) begin
				next_rdata = timers[t].period_timer_control;
			end
			if (bus_i.rd && bus_i.addr == timer_addr(SPWM_ADDR_PERIOD_LIMIT, t)) begin
				next_rdata = timers[t].period_limit;
			end
			if (bus_i.rd && bus_i.addr == timer_addr(SPWM_ADDR_PERIOD_COUNT, t)) begin
				next_rdata = timers[t].period_count;
			end
		end
		if (bus_i.wr) begin
			case (bus_i.addr)
				SPWM_ADDR_CONTROL: next_control = spwm_control_s'(bus_i.wdata);
				SPWM_ADDR_DUTY_UPPER: next_duty_upper_byte = bus_i.wdata;
				SPWM_ADDR_TIMER_SELECT: next_timer_select_field = bus_i.wdata[1:0];
				default: ;
			endcase
		end
		if (bus_i.rd) begin
			case (bus_i.addr)
				SPWM_ADDR_CONTROL: next_rdata = control;
				SPWM_ADDR_DUTY_UPPER: next_rdata = duty_upper_byte;
				SPWM_ADDR_DUTY_SHADOW: next_rdata = duty_shadow[9:2];
				SPWM_ADDR_TIMER_SELECT: next_rdata = {6'h00, timer_select_field};
				SPWM_ADDR_FLAGS: begin
					for (int t = 0; t < NUM_TIMERS; t++) begin
						next_rdata[t] = timers[t].period_flag;
					end
				end
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			control <= spwm_control_s'(SPWM_RST_CONTROL);
			duty_upper_byte <= SPWM_RST_DUTY;
			duty_shadow <= 10'h000;
			timer_select_field <= SPWM_RST_TSEL;
			osc_phase <= 2'h0;
			pwm <= 1'b0;
			oe_n <= 1'b1;
			owned <= 1'b0;
			rdata <= 8'h00;
			for (int t = 0; t < NUM_TIMERS; t++) begin
				timers[t] <= '{SPWM_RST_LIMIT, 8'h00, SPWM_RST_TCON, 1'b0, 6'h00};
			end
		end else begin
			control <= next_control;
			duty_upper_byte <= next_duty_upper_byte;
			duty_shadow <= next_duty_shadow;
			timer_select_field <= next_timer_select_field;
			osc_phase <= next_osc_phase;
			pwm <= next_pwm;
			oe_n <= next_oe_n;
			owned <= next_owned;
			rdata <= next_rdata;
			for (int t = 0; t < NUM_TIMERS; t++) begin
				timers[t] <= next_timers[t];
			end
		end
	end

	assign rdata_o = rdata;
	assign pwm_o = pwm;
	assign pwm_oe_n_o = oe_n;
	assign pin_owned_o = owned;

endmodule

/* spwm_channel_checker.sv */
// Port checker of the standard PWM channel.
// Assumes one clock and a synchronous active-low reset; bound to every channel.
`timescale 1ns/10ps
module spwm_channel_checker
	import spwm_pkg::*;
#(
	parameter int NUM_TIMERS = 3
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Register port
	input wire spwm_pkg::spwm_bus_s bus_i,
	input wire logic [7:0] rdata_o,
	// System and pin
	input wire logic sleep_i,
	input wire logic pwm_o,
	input wire logic pwm_oe_n_o,
	input wire logic pin_owned_o
);
	import spwm_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	////////////////////////////////////////////////////////////////
	logic [7:0] ctl, dup, lim0, next_ctl, next_dup, next_lim0;
	// Software copy of the written registers
	always_comb begin
		next_ctl = ctl;
		next_dup = dup;
		next_lim0 = lim0;
		if (bus_i.wr && bus_i.addr == SPWM_ADDR_CONTROL) next_ctl = bus_i.wdata;
		if (bus_i.wr && bus_i.addr == SPWM_ADDR_DUTY_UPPER) next_dup = bus_i.wdata;
		if (bus_i.wr && bus_i.addr == SPWM_ADDR_PERIOD_LIMIT) next_lim0 = bus_i.wdata;
	end
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			ctl <= SPWM_RST_CONTROL;
			dup <= SPWM_RST_DUTY;
			lim0 <= SPWM_RST_LIMIT;
		end else begin
			ctl <= next_ctl;
			dup <= next_dup;
			lim0 <= next_lim0;
		end
	end
	////////////////////////////////////////////////////////////////
	property p_ctl_read;
		bus_i.rd && bus_i.addr == SPWM_ADDR_CONTROL |=> rdata_o == ctl;
	endproperty
	a_ctl_read: assert property (p_ctl_read) else $error("control readback wrong");
	property p_dup_read;
		bus_i.rd && bus_i.addr == SPWM_ADDR_DUTY_UPPER |=> rdata_o == dup;
	endproperty
	a_dup_read: assert property (p_dup_read) else $error("duty readback wrong");
	property p_lim_read;
		bus_i.rd && bus_i.addr == SPWM_ADDR_PERIOD_LIMIT |=> rdata_o == lim0;
	endproperty
	a_lim_read: assert property (p_lim_read) else $error("limit readback wrong");
	property p_idle_rd;
		!bus_i.rd |=> rdata_o == 8'h00;
	endproperty
	a_idle_rd: assert property (p_idle_rd) else $error("read data not cleared");
	property p_release;
		bus_i.wr && bus_i.addr == SPWM_ADDR_CONTROL && bus_i.wdata == 8'h00
			|-> ##[1:2] !pin_owned_o && pwm_oe_n_o;
	endproperty
	a_release: assert property (p_release) else $error("pin not released");
	property p_oe_owned;
		!pwm_oe_n_o |-> pin_owned_o;
	endproperty
	a_oe_owned: assert property (p_oe_owned) else $error("driving unowned pin");
	property p_other_mode;
		bus_i.wr && bus_i.addr == SPWM_ADDR_CONTROL && bus_i.wdata[3:0] != SPWM_MODE_PWM
			|-> ##[1:2] pwm_oe_n_o;
	endproperty
	a_other_mode: assert property (p_other_mode) else $error("driver on outside mode");
	property p_rise_mode;
		$rose(pwm_o) |-> $past(ctl[3:0]) == SPWM_MODE_PWM || ctl[3:0] == SPWM_MODE_PWM;
	endproperty
	a_rise_mode: assert property (p_rise_mode) else $error("pulse outside mode");
	property p_sleep_pin;
		(sleep_i && !bus_i.wr) [*2] |=> $stable(pwm_o);
	endproperty
	a_sleep_pin: assert property (p_sleep_pin) else $error("pin moved in sleep");
endmodule
bind spwm_channel spwm_channel_checker #(.NUM_TIMERS(NUM_TIMERS)) spwm_channel_checker_i (
	.clk_i(clk_i), .nrst_i(nrst_i), .bus_i(bus_i), .rdata_o(rdata_o), .sleep_i(sleep_i),
	.pwm_o(pwm_o), .pwm_oe_n_o(pwm_oe_n_o), .pin_owned_o(pin_owned_o));

/* spwm_load.sv */
// Load on the modulated pin: counts high cycles and rising edges.
// Assumes a pull-down on the pin and a direction bit held by the bench.
`timescale 1ns/10ps
module spwm_load (
	input wire logic clk_i,
	input wire logic pwm_i,
	input wire logic oe_n_i,
	input wire logic dir_out_i,
	output int n_rise,
	output int n_high
);
	logic pin, pin_d;
	assign pin = (!oe_n_i && dir_out_i) ? pwm_i : 1'b0;
	initial begin
		n_rise = 0;
		n_high = 0;
		pin_d = 1'b0;
	end
	always @(posedge clk_i) begin
		pin_d <= pin;
		if (pin === 1'b1) n_high <= n_high + 1;
		if (pin === 1'b1 && pin_d === 1'b0) n_rise <= n_rise + 1;
	end
endmodule

/* spwm_channel_tb.sv */
// Self-checking bench of the standard PWM channel.
// Assumes the register map of the package and timer 0 as the main time base.
`timescale 1ns/10ps
module spwm_channel_tb;
	import spwm_pkg::*;
	logic clk_i, nrst_i, sleep_i, dir_out, pwm, oe_n, owned;
	spwm_bus_s bus;
	logic [7:0] rdata, v;
	int n_rise, n_high, n_mismatch = 0, n_compared = 0, k, r0;
	int tc[5] = '{4, 5, 6, 7, 124};
	int lim[5] = '{3, 3, 0, 0, 3};
	int du[5] = '{6, 6, 3, 1, 6};
	int per[5] = '{16, 64, 64, 256, 16};
	int hi[5] = '{6, 24, 48, 64, 6};
	spwm_channel spwm_channel_i (.clk_i(clk_i), .nrst_i(nrst_i), .bus_i(bus), .rdata_o(rdata),
		.sleep_i(sleep_i), .pwm_o(pwm), .pwm_oe_n_o(oe_n), .pin_owned_o(owned));
	spwm_load spwm_load_i (.clk_i(clk_i), .pwm_i(pwm), .oe_n_i(oe_n), .dir_out_i(dir_out),
		.n_rise(n_rise), .n_high(n_high));
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_i);
		bus <= '0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_i);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_i);
		bus <= '0;
		#1 d = rdata;
	endtask
	task automatic set_duty(input logic [9:0] d);
		wr(SPWM_ADDR_DUTY_UPPER, d[9:2]);
		wr(SPWM_ADDR_CONTROL, {2'h0, d[1:0], SPWM_MODE_PWM});
	endtask
	// Sync to the second fresh pulse unless none is expected, then count over two periods
	task automatic meas(input int p, input int nr, input int h);
		int h0;
		r0 = n_rise;
		for (k = 0; k < 3000 && nr > 0 && n_rise < r0 + 2; k++) @(posedge clk_i);
		if (nr == 0) repeat (2 * p) @(posedge clk_i);
		r0 = n_rise;
		h0 = n_high;
		repeat (2 * p) @(posedge clk_i);
		chk(n_rise - r0, nr);
		chk(n_high - h0, h);
	endtask
	task automatic print_verdict;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		bus = '0;
		sleep_i = 1'b0;
		dir_out = 1'b0;
		nrst_i = 1'b0;
		repeat (4) @(posedge clk_i);
		nrst_i <= 1'b1;
		rd(SPWM_ADDR_PERIOD_LIMIT, v);
		chk(v, SPWM_RST_LIMIT);
		rd(SPWM_ADDR_DUTY_SHADOW, v);
		chk(v, SPWM_RST_DUTY);
		rd(4'hf, v);
		chk(v, 8'h00);
		wr(SPWM_ADDR_PERIOD_LIMIT, 8'h03);
		set_duty(10'h006);
		wr(SPWM_ADDR_TIMER_SELECT, 8'h00);
		wr(SPWM_ADDR_FLAGS, 8'h01);
		wr(SPWM_ADDR_TIMER_CONTROL, 8'h04);
		v = 8'h00;
		for (k = 0; k < 50 && v === 8'h00; k++) rd(SPWM_ADDR_FLAGS, v);
		chk(v, 8'h01);
		dir_out <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			wr(SPWM_ADDR_TIMER_CONTROL, 8'(tc[i]));
			wr(SPWM_ADDR_PERIOD_LIMIT, 8'(lim[i]));
			wr(SPWM_ADDR_PERIOD_COUNT, 8'h00);
			set_duty(10'(du[i]));
			meas(per[i], 2, 2 * hi[i]);
		end
		wr(SPWM_ADDR_DUTY_SHADOW, 8'h55);
		rd(SPWM_ADDR_DUTY_SHADOW, v);
		chk(v, 8'h01);
		set_duty(10'h00a);
		meas(16, 2, 20);
		set_duty(10'h3ff);
		meas(16, 0, 32);
		set_duty(10'h000);
		meas(16, 0, 0);
		set_duty(10'h006);
		wr(4'(SPWM_ADDR_PERIOD_LIMIT + 2 * SPWM_TIMER_STRIDE), 8'h07);
		wr(4'(SPWM_ADDR_TIMER_CONTROL + 2 * SPWM_TIMER_STRIDE), 8'h04);
		wr(SPWM_ADDR_TIMER_SELECT, 8'h02);
		meas(32, 2, 12);
		@(posedge clk_i);
		sleep_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		r0 = n_rise;
		repeat (40) @(posedge clk_i);
		sleep_i <= 1'b0;
		chk(n_rise - r0, 0);
		wr(SPWM_ADDR_CONTROL, 8'h00);
		repeat (2) @(posedge clk_i);
		#1 chk({owned, oe_n}, 2'h1);
		set_duty(10'h006);
		repeat (2) @(posedge clk_i);
		#1 chk({owned, oe_n}, 2'h2);
		wr(SPWM_ADDR_CONTROL, {4'h0, ~SPWM_MODE_PWM});
		repeat (2) @(posedge clk_i);
		#1 chk({owned, oe_n, pwm}, 3'h2);
		print_verdict;
	end
	initial begin
		repeat (30000) @(posedge clk_i);
		n_mismatch++;
		print_verdict;
	end
endmodule
